// ==== src/ela_top.sv ====
/*
 Embedded logic analyzer: match units, capture control, sample memory,
 APB control registers and serial scan readout.
 Assumes trigger and data inputs are on MCLK; TCK and SCAN_SEL are not.
*/
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ela_top
   import ela_pkg::*;
#(
   parameter int N_TRIG      = 1,
   parameter int TRIG_W      = 8,
   parameter int N_MU        = 1,
   parameter int MATCH_CLASS = 1,
   parameter int DATA_W      = 32,
   parameter int DEPTH       = 1024
) (
   input  wire logic                     MCLK,
   input  wire logic                     RST_B,
   input  wire logic                     PSEL,
   input  wire logic                     PENABLE,
   input  wire logic                     PWRITE,
   input  wire logic [7:0]               PADDR,
   input  wire logic [31:0]              PWDATA,
   output var  logic [31:0]              PRDATA,
   output var  logic                     PREADY,
   output var  logic                     PSLVERR,
   input  wire logic [N_TRIG*TRIG_W-1:0] TRIG_IN,
   input  wire logic [DATA_W-1:0]        DATA_IN,
   input  wire logic                     TCK,
   input  wire logic                     SCAN_SEL,
   output var  logic                     TDO,
   output var  logic                     IRQ
);
   localparam int AW  = $clog2(DEPTH);
   localparam int N_U = N_TRIG * N_MU;
   localparam int UW  = (N_U > 1) ? $clog2(N_U) : 1;
   localparam int BW  = $clog2(DATA_W);

   ////////////////////////////////////////////////////////////////////////
   if (N_TRIG < 1 || N_TRIG > MAX_TRIG) begin : g_chk_trig
      $error("trigger port count out of range");
   end
   if (N_MU < 1 || N_MU > MAX_MU) begin : g_chk_mu
      $error("match unit count out of range");
   end
   if (MATCH_CLASS < CLS_BASIC || MATCH_CLASS > CLS_MAX
       || TRIG_W < 1 || TRIG_W > 32) begin : g_chk_cls
      $error("match class or trigger width unsupported");
   end
   if (DATA_W < 2 || DATA_W > MAX_DATA) begin : g_chk_data
      $error("sample width out of range");
   end
   if (DEPTH < MIN_DEPTH || DEPTH > MAX_DEPTH
       || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk_depth
      $error("capture depth not a legal power of two");
   end

   typedef struct packed {
      ela_state_t                   st;
      logic [AW-1:0]                wr_ptr;
      logic [AW-1:0]                rd_ptr;
      logic                         or_mode;
      logic [UW-1:0]                usel;
      logic [N_U-1:0][TRIG_W-1:0]   ua;
      logic [N_U-1:0][TRIG_W-1:0]   ub;
      logic [N_U-1:0][3:0]          uop;
      logic [N_U-1:0]               uen;
      logic [N_TRIG*TRIG_W-1:0]     prev;
      logic [1:0]                   istat;
      logic [1:0]                   imask;
      logic [31:0]                  prdata;
      logic                         tck1;
      logic                         tck2;
      logic                         tck3;
      logic                         sel1;
      logic                         sel2;
      logic                         sel3;
      logic [DATA_W-1:0]            shift;
      logic [BW-1:0]                bcnt;
      logic [1:0]                   pend;
   } ela_reg_t;

   ela_reg_t          r;
   ela_reg_t          next_r;
   ela_apb_t          bus;
   logic [N_U-1:0]    u_hit;
   logic              hit;
   logic              wr_en;
   logic              mapped;
   logic [31:0]       rd_val;
   logic [1:0]        iset;
   logic [DATA_W-1:0] mem [DEPTH];
   logic [DATA_W-1:0] mem_q;

   ////////////////////////////////////////////////////////////////////////
   // Ops outside the configured class never match
   function automatic logic f_match(input logic [TRIG_W-1:0] c,
                                    input logic [TRIG_W-1:0] p,
                                    input logic [TRIG_W-1:0] a,
                                    input logic [TRIG_W-1:0] b,
                                    input logic [3:0] op);
      logic ext;
      logic rng;
      logic edg;
      ext = MATCH_CLASS >= CLS_EXT;
      rng = MATCH_CLASS >= CLS_RANGE;
      edg = (MATCH_CLASS % 2) == 1;
      case (op)
         OP_EQ:   f_match = c == a;
         OP_NE:   f_match = c != a;
         OP_GT:   f_match = ext && c > a;
         OP_LT:   f_match = ext && c < a;
         OP_LE:   f_match = ext && c <= a;
         OP_GE:   f_match = ext && c >= a;
         OP_IN:   f_match = rng && c >= a && c <= b;
         OP_OUT:  f_match = rng && (c < a || c > b);
         // A selects which bits are watched for an edge
         OP_RISE: f_match = edg && |(~p & c & a);
         OP_FALL: f_match = edg && |(p & ~c & a);
         default: f_match = 1'b0;
      endcase
   endfunction

   for (genvar u = 0; u < N_U; u++) begin : g_unit
      localparam int P = u / N_MU;
      assign u_hit[u] = f_match(TRIG_IN[P*TRIG_W +: TRIG_W],
                                r.prev[P*TRIG_W +: TRIG_W],
                                r.ua[u], r.ub[u], r.uop[u]);
   end

   // No enabled unit means no condition: trigger at once
   assign hit = (r.uen == '0)
                || (r.or_mode ? |(u_hit & r.uen)
                              : &(u_hit | ~r.uen));

   ////////////////////////////////////////////////////////////////////////
   // APB slave, zero wait states, read data caught in setup
   assign bus.access = PSEL & PENABLE;
   assign bus.setup  = PSEL & ~PENABLE;
   assign bus.write  = PWRITE;
   assign bus.addr   = PADDR;
   assign bus.wdata  = PWDATA;

   always_comb begin
      mapped = 1'b1;
      rd_val = 32'h0000_0000;
      if (bus.addr == ADDR_CTRL) begin
         rd_val[CTRL_OR] = r.or_mode;
      end else if (bus.addr == ADDR_STATUS) begin
         rd_val[0] = r.st == ST_ARMED;
         rd_val[1] = r.st == ST_CAPT;
         rd_val[2] = r.st == ST_DONE;
         rd_val[STAT_WPTR +: AW] = r.wr_ptr;
      end else if (bus.addr == ADDR_UNIT_SEL) begin
         rd_val = 32'(r.usel);
      end else if (bus.addr == ADDR_UNIT_A) begin
         rd_val = 32'(r.ua[r.usel]);
      end else if (bus.addr == ADDR_UNIT_B) begin
         rd_val = 32'(r.ub[r.usel]);
      end else if (bus.addr == ADDR_UNIT_CFG) begin
         rd_val = 32'({r.uen[r.usel], r.uop[r.usel]});
      end else if (bus.addr == ADDR_INT_STAT) begin
         rd_val = 32'(r.istat);
      end else if (bus.addr == ADDR_INT_MASK) begin
         rd_val = 32'(r.imask);
      end else if (bus.addr == ADDR_RD_PTR) begin
         rd_val = 32'(r.rd_ptr);
      end else begin
         mapped = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_r = r;
      wr_en = 1'b0;
      iset = 2'b00;
      next_r.prev = TRIG_IN;
      case (r.st)
         ST_ARMED: begin
            if (hit) begin
               wr_en = 1'b1;
               iset[INT_TRIG] = 1'b1;
               next_r.wr_ptr = r.wr_ptr + 1'b1;
               next_r.st = ST_CAPT;
            end
         end
         ST_CAPT: begin
            wr_en = 1'b1;
            next_r.wr_ptr = r.wr_ptr + 1'b1;
            if (r.wr_ptr == AW'(DEPTH - 1)) begin
               next_r.st = ST_DONE;
               iset[INT_DONE] = 1'b1;
            end
         end
         default: begin
         end
      endcase
      if (bus.setup) begin
         next_r.prdata = rd_val;
      end
      if (bus.access && bus.write) begin
         if (bus.addr == ADDR_CTRL) begin
            next_r.or_mode = bus.wdata[CTRL_OR];
            if (bus.wdata[CTRL_ABORT]) begin
               next_r.st = ST_IDLE;
            end else if (bus.wdata[CTRL_ARM]) begin
               next_r.st = ST_ARMED;
               next_r.wr_ptr = '0;
            end
         end else if (bus.addr == ADDR_UNIT_SEL) begin
            if (bus.wdata < 32'(N_U)) begin
               next_r.usel = bus.wdata[UW-1:0];
            end
         end else if (bus.addr == ADDR_UNIT_A) begin
            next_r.ua[r.usel] = bus.wdata[TRIG_W-1:0];
         end else if (bus.addr == ADDR_UNIT_B) begin
            next_r.ub[r.usel] = bus.wdata[TRIG_W-1:0];
         end else if (bus.addr == ADDR_UNIT_CFG) begin
            next_r.uop[r.usel] = bus.wdata[3:0];
            next_r.uen[r.usel] = bus.wdata[CFG_EN];
         end else if (bus.addr == ADDR_INT_MASK) begin
            next_r.imask = bus.wdata[1:0];
         end else if (bus.addr == ADDR_RD_PTR) begin
            next_r.rd_ptr = bus.wdata[AW-1:0];
         end
      end
      // Set beats the write-one clear in the same cycle
      if (bus.access && bus.write && bus.addr == ADDR_INT_STAT) begin
         next_r.istat = (r.istat & ~bus.wdata[1:0]) | iset;
      end else begin
         next_r.istat = r.istat | iset;
      end
      // Scan readout: TCK is only sampled, edges found here
      next_r.tck1 = TCK;
      next_r.tck2 = r.tck1;
      next_r.tck3 = r.tck2;
      next_r.sel1 = SCAN_SEL;
      next_r.sel2 = r.sel1;
      next_r.sel3 = r.sel2;
      if (r.sel2 && !r.sel3) begin
         next_r.shift = mem_q;
         next_r.bcnt = '0;
         next_r.pend = 2'b00;
      end else if (r.pend != 2'b00) begin
         // Memory read takes two cycles after the pointer moves
         next_r.pend = r.pend - 1'b1;
         if (r.pend == 2'b01) begin
            next_r.shift = mem_q;
         end
      end else if (r.sel2 && !r.tck2 && r.tck3) begin
         next_r.shift = r.shift >> 1;
         if (r.bcnt == BW'(DATA_W - 1)) begin
            next_r.bcnt = '0;
            next_r.rd_ptr = r.rd_ptr + 1'b1;
            next_r.pend = PEND_LOAD;
         end else begin
            next_r.bcnt = r.bcnt + 1'b1;
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         r <= '0;
         r.st <= ST_IDLE;
         r.imask <= INT_MASK_RST;
      end else begin
         r <= next_r;
      end
   end

   // Sample memory, no reset so it maps to block RAM
   always_ff @(posedge MCLK) begin
      if (wr_en) begin
         mem[r.wr_ptr] <= DATA_IN;
      end
      mem_q <= mem[r.rd_ptr];
   end

   assign PRDATA  = r.prdata;
   assign PREADY  = 1'b1;
   assign PSLVERR = bus.access & ~mapped;
   assign TDO     = r.shift[0];
   assign IRQ     = |(r.istat & r.imask);

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_B);

   no_cond_a: assert property (
      r.st == ST_ARMED && r.uen == '0 && !(bus.access && bus.write)
      |=> r.st == ST_CAPT && r.wr_ptr == AW'(1))
      else $error("armed without condition did not capture");
   hold_armed_a: assert property (
      r.st == ST_ARMED && !hit |-> !wr_en)
      else $error("sample written before trigger");
   full_done_a: assert property (
      r.st == ST_CAPT && r.wr_ptr == AW'(DEPTH - 1)
      && !(bus.access && bus.write)
      |=> r.st == ST_DONE && r.istat[INT_DONE])
      else $error("full buffer not reported");
   per_cycle_a: assert property (
      r.st == ST_CAPT && $past(r.st) == ST_CAPT
      |-> r.wr_ptr == $past(r.wr_ptr) + 1'b1)
      else $error("capture skipped a cycle");
   unit_eq_a: assert property (
      r.uen[0] && r.uop[0] == OP_EQ
      |-> u_hit[0] == (TRIG_IN[TRIG_W-1:0] == r.ua[0]))
      else $error("equality match wrong");
   class_gate_a: assert property (
      (MATCH_CLASS < CLS_EXT && r.uop[0] >= OP_GT && r.uop[0] <= OP_GE)
      || (MATCH_CLASS < CLS_RANGE && r.uop[0] >= OP_IN
          && r.uop[0] <= OP_OUT) |-> !u_hit[0])
      else $error("operation outside class matched");
   rise_edge_a: assert property (
      (MATCH_CLASS % 2) == 1 && r.uop[0] == OP_RISE
      |-> u_hit[0] == |(~r.prev[TRIG_W-1:0] & TRIG_IN[TRIG_W-1:0]
                        & r.ua[0]))
      else $error("rising edge match wrong");
   value_write_a: assert property (
      bus.access && bus.write && bus.addr == ADDR_UNIT_A
      |=> r.ua[$past(r.usel)] == $past(bus.wdata[TRIG_W-1:0]))
      else $error("match value not written");
   irq_sticky_a: assert property (
      r.istat[INT_TRIG] && !(bus.access && bus.write
      && bus.addr == ADDR_INT_STAT) |=> r.istat[INT_TRIG])
      else $error("status bit lost");
   scan_load_a: assert property (
      r.sel2 && !r.sel3 |=> r.shift == $past(mem_q) && r.bcnt == '0)
      else $error("scan word not loaded on select");
   scan_hold_a: assert property (
      !r.sel2 && r.pend == 2'b00 |=> $stable(r.shift))
      else $error("scan word moved while deselected");

   trig_cov: cover property (r.st == ST_ARMED ##1 r.st == ST_CAPT);
   done_cov: cover property (r.st == ST_CAPT ##1 r.st == ST_DONE);
   scan_cov: cover property (r.pend == PEND_LOAD);
   or_cov: cover property (r.or_mode && r.st == ST_ARMED ##1 r.st == ST_CAPT);
endmodule
`default_nettype wire

// ==== src/ela_pkg.sv ====
/*
 Constants, states and carriers shared by the embedded logic analyzer.
 Assumes an APB bridge behind the boundary-scan port drives the registers.
*/
`default_nettype none
package ela_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CAPT, ST_DONE} ela_state_t;

   // Match operation codes held in UNIT_CFG
   localparam logic [3:0] OP_EQ   = 4'h0;
   localparam logic [3:0] OP_NE   = 4'h1;
   localparam logic [3:0] OP_GT   = 4'h2;
   localparam logic [3:0] OP_LT   = 4'h3;
   localparam logic [3:0] OP_LE   = 4'h4;
   localparam logic [3:0] OP_GE   = 4'h5;
   localparam logic [3:0] OP_IN   = 4'h6;
   localparam logic [3:0] OP_OUT  = 4'h7;
   localparam logic [3:0] OP_RISE = 4'h8;
   localparam logic [3:0] OP_FALL = 4'h9;

   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_STATUS   = 8'h04;
   localparam logic [7:0] ADDR_UNIT_SEL = 8'h08;
   localparam logic [7:0] ADDR_UNIT_A   = 8'h0C;
   localparam logic [7:0] ADDR_UNIT_B   = 8'h10;
   localparam logic [7:0] ADDR_UNIT_CFG = 8'h14;
   localparam logic [7:0] ADDR_INT_STAT = 8'h18;
   localparam logic [7:0] ADDR_INT_MASK = 8'h1C;
   localparam logic [7:0] ADDR_RD_PTR   = 8'h20;

   localparam int CTRL_ARM   = 0;
   localparam int CTRL_ABORT = 1;
   localparam int CTRL_OR    = 2;
   localparam int CFG_EN     = 4;
   localparam int INT_TRIG   = 0;
   localparam int INT_DONE   = 1;
   localparam int STAT_WPTR  = 16;

   localparam logic [1:0] INT_MASK_RST = 2'h0;
   localparam logic [1:0] PEND_LOAD    = 2'h2;

   // Configured classes, odd values are the edge variants
   localparam int CLS_BASIC = 0;
   localparam int CLS_EXT   = 2;
   localparam int CLS_RANGE = 4;
   localparam int CLS_MAX   = 5;

   localparam int MAX_TRIG  = 16;
   localparam int MAX_MU    = 4;
   localparam int MAX_DATA  = 256;
   localparam int MIN_DEPTH = 1024;
   localparam int MAX_DEPTH = 16384;

   typedef struct packed {
      logic access;
      logic setup;
      logic write;
      logic [7:0] addr;
      logic [31:0] wdata;
   } ela_apb_t;
endpackage
`default_nettype wire

// ==== verif/ela_host_model.sv ====
/*
 Host-side scan reader standing in for the analyzer software.
 Assumes TDO shifts LSB first on TCK falls and is seen a few MCLK later.
*/
`timescale 1ns/1ns
`default_nettype none
module ela_host_model #(
   parameter int DATA_W = 32
) (
   output var  logic TCK,
   output var  logic SCAN_SEL,
   input  wire logic TDO
);
   initial begin
      TCK      = 1'b0;
      SCAN_SEL = 1'b0;
   end

   // Two samples per frame; TCK idles low outside frames
   task automatic read_pair(output logic [2*DATA_W-1:0] v);
      SCAN_SEL = 1'b1;
      #600;
      for (int i = 0; i < 2*DATA_W; i++) begin
         TCK  = 1'b1;
         v[i] = TDO;
         #400;
         TCK = 1'b0;
         #400;
         // Next word reloads about five MCLK after the last fall
         if (i % DATA_W == DATA_W - 1) begin
            #800;
         end
      end
      SCAN_SEL = 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
/*
 Self-checking bench: APB registers, match operations, edge triggers,
 free-run capture with interrupts, and serial readout.
 Assumes the host model for the scan side and the design package.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import ela_pkg::*;
   localparam int DW = 32;
   localparam int DP = 1024;
   logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr;
   logic        tck, scan_sel, tdo, irq;
   logic [7:0]  paddr, trig;
   logic [31:0] pwdata, prdata, data;
   int          mismatches, checks_done;

   ela_top #(.N_TRIG(1), .TRIG_W(8), .N_MU(2), .MATCH_CLASS(CLS_MAX),
      .DATA_W(DW), .DEPTH(DP)) ela_top_inst (
      .MCLK(mclk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .TRIG_IN(trig),
      .DATA_IN(data), .TCK(tck), .SCAN_SEL(scan_sel), .TDO(tdo),
      .IRQ(irq));
   ela_host_model #(.DATA_W(DW)) ela_host_model_inst (
      .TCK(tck), .SCAN_SEL(scan_sel), .TDO(tdo));

   always #50 mclk = ~mclk;
   always @(posedge mclk) begin
      data <= data + 32'h1;
   end

   ////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      if (mismatches == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic err);
      int n;
      @(posedge mclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         chk({31'h0, pready}, 32'h1);
         tally_and_finish;
      end
      q       = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask

   task automatic irq_is(input logic exp);
      repeat (2) @(posedge mclk);
      #1;
      chk({31'h0, irq}, {31'h0, exp});
   endtask

   function automatic logic hit(input logic [7:0] c, a, b,
      input logic [3:0] op);
      case (op)
         OP_EQ: return c == a;
         OP_NE: return c != a;
         OP_GT: return c > a;
         OP_LT: return c < a;
         OP_LE: return c <= a;
         OP_GE: return c >= a;
         OP_IN: return c >= a && c <= b;
         default: return c < a || c > b;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////
   task automatic t_regs;
      logic [31:0] q;
      logic        e;
      rd(ADDR_STATUS, q);
      chk(q, 32'h0);
      rd(ADDR_INT_MASK, q);
      chk(q, {30'h0, INT_MASK_RST});
      apb(1'b0, 8'h24, 32'h0, q, e);
      chk({q[30:0], e}, 32'h1);
      irq_is(1'b0);
   endtask

   task automatic t_ops(input logic [7:0] c);
      logic [31:0] q;
      logic        want;
      wr(ADDR_UNIT_SEL, 32'h0);
      wr(ADDR_UNIT_A, 32'h40);
      wr(ADDR_UNIT_B, 32'h50);
      for (int op = 0; op < 8; op++) begin
         trig <= c;
         wr(ADDR_CTRL, 32'h2);
         wr(ADDR_UNIT_CFG, 32'h10 | op);
         wr(ADDR_CTRL, 32'h1);
         rd(ADDR_STATUS, q);
         want = hit(c, 8'h40, 8'h50, 4'(op));
         chk(32'(|q[2:1]), 32'(want));
      end
   endtask

   task automatic t_edge(input logic [3:0] op, input logic [7:0] idle);
      logic [31:0] q;
      trig <= idle;
      wr(ADDR_CTRL, 32'h2);
      wr(ADDR_UNIT_A, 32'h01);
      wr(ADDR_UNIT_CFG, {27'h0, 1'b1, op});
      wr(ADDR_CTRL, 32'h1);
      rd(ADDR_STATUS, q);
      chk(32'(q[2:0]), 32'h1);
      trig <= ~idle;
      rd(ADDR_STATUS, q);
      chk(32'(q[2:0]), 32'h2);
   endtask

   // Unit 0 matches, unit 1 does not: AND holds off, OR triggers
   task automatic t_comb;
      logic [31:0] q;
      trig <= 8'h40;
      wr(ADDR_CTRL, 32'h2);
      wr(ADDR_UNIT_SEL, 32'h1);
      wr(ADDR_UNIT_A, 32'h41);
      wr(ADDR_UNIT_CFG, 32'h10);
      wr(ADDR_UNIT_SEL, 32'h0);
      wr(ADDR_UNIT_A, 32'h40);
      wr(ADDR_UNIT_CFG, 32'h10);
      for (int m = 0; m < 2; m++) begin
         wr(ADDR_CTRL, 32'h2 | (m << 2));
         wr(ADDR_CTRL, 32'h1 | (m << 2));
         rd(ADDR_STATUS, q);
         chk({31'h0, q[1]}, 32'(m));
         rd(ADDR_CTRL, q);
         chk(q, 32'(m << 2));
      end
      wr(ADDR_CTRL, 32'h2);
      wr(ADDR_UNIT_SEL, 32'h1);
      wr(ADDR_UNIT_CFG, 32'h0);
      wr(ADDR_UNIT_SEL, 32'h0);
      wr(ADDR_UNIT_SEL, 32'h2);
      rd(ADDR_UNIT_SEL, q);
      chk(q, 32'h0);
   endtask

   task automatic t_free;
      logic [31:0] q, a0;
      logic [63:0] v;
      int          n;
      wr(ADDR_CTRL, 32'h2);
      wr(ADDR_UNIT_CFG, 32'h0);
      wr(ADDR_INT_STAT, 32'h3);
      a0 = data;
      wr(ADDR_CTRL, 32'h1);
      n = 0;
      do begin
         rd(ADDR_STATUS, q);
         n++;
      end while (q[2] !== 1'b1 && n < 600);
      if (q[2] !== 1'b1) begin
         chk(q, 32'h4);
         tally_and_finish;
      end
      rd(ADDR_INT_STAT, q);
      chk(q, 32'h3);
      irq_is(1'b0);
      wr(ADDR_INT_MASK, 32'h3);
      irq_is(1'b1);
      wr(ADDR_INT_STAT, 32'h1);
      rd(ADDR_INT_STAT, q);
      chk(q, 32'h2);
      wr(ADDR_INT_STAT, 32'h2);
      irq_is(1'b0);
      wr(ADDR_RD_PTR, 32'h0);
      ela_host_model_inst.read_pair(v);
      chk(v[63:32], v[31:0] + 32'h1);
      chk({31'h0, v[31:0] - a0 < 32'h10}, 32'h1);
      a0 = v[31:0];
      wr(ADDR_RD_PTR, DP - 1);
      ela_host_model_inst.read_pair(v);
      chk(v[31:0], a0 + DP - 1);
      chk(v[63:32], a0);
   endtask

   initial begin
      mclk    = 1'b0;
      rst_b   = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      trig    = 8'h00;
      data    = 32'h0;
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      t_regs;
      t_ops(8'h40);
      t_ops(8'h60);
      t_edge(OP_RISE, 8'h00);
      t_edge(OP_FALL, 8'hFF);
      t_comb;
      t_free;
      tally_and_finish;
   end
endmodule
`default_nettype wire
